// *** driver_ready_start_gating.v ***
// start gating on driver ready, with axi4-lite registers and interrupt
//
// Summary of operation
// - gate enable takes values 0 or 1
// - new enable active only after save and reset
// - power up restores last saved enable
// - never saved: factory default enable
// - enable writes refused while program runs
// - enabled gate samples driver ready at start
// - driver ready high: start immediately
// - driver ready low: hold, start on rise
// - pending three seconds: raise alarm 6Fh
// - enabled: ready needs idle and driver ready
// - disabled: ready needs only controller idle
`timescale 1ns/1ps
`include "drv_gate_regs.vh"
module driver_ready_start_gating #(
  parameter [31:0] TIMEOUT_CYCLES = `DRV_TIMEOUT_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire driver_ready_pin,
  input wire motion_start_request,
  input wire controller_moving,
  input wire program_running,
  input wire controller_alarm,
  input wire nv_saved_valid,
  input wire nv_saved_value,
  output reg nv_write,
  output reg nv_write_value,
  output reg pulse_generation_start,
  output reg start_pending,
  output reg driver_connection_alarm,
  output reg [7:0] alarm_code,
  output reg controller_ready_output_state,
  output reg remote_ready_output_state,
  output wire irq
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;
  localparam [31:0] TIMEOUT_LAST = TIMEOUT_CYCLES - 32'h0000_0001;

  wire driver_ready_input_state;
  reg driver_ready_gate_enable;
  reg pending_gate_enable;
  reg reload_pending;
  reg [1:0] state;
  reg [26:0] wait_count;
  reg [`IRQ_WIDTH-1:0] irq_status;
  reg [`IRQ_WIDTH-1:0] irq_mask;
  reg ev_alarm;
  reg ev_started;
  reg ev_refused;

  // ----------------------------------------------------------------------
  // driver ready pin
  // ----------------------------------------------------------------------
  pin_sync3 pin_sync3_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(driver_ready_pin),
    .level(driver_ready_input_state)
  );

  // ----------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------
  reg aw_held;
  reg w_held;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire wr_do;
  wire wr_ctl;
  wire wr_refused;
  wire wr_mapped;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_do = aw_held && w_held && !s_axi_bvalid;
  assign wr_mapped = (awaddr_q == `OFS_CONTROL) ||
                     (awaddr_q == `OFS_IRQ_STATUS) ||
                     (awaddr_q == `OFS_IRQ_MASK);
  assign wr_ctl = wr_do && (awaddr_q == `OFS_CONTROL) && wstrb_q[0];
  // writes to the enable are locked out while a program runs
  assign wr_refused = wr_ctl && program_running;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (!wr_mapped || wr_refused) begin
          s_axi_bresp <= `RESP_SLVERR;
        end else begin
          s_axi_bresp <= `RESP_OKAY;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // gate enable: written copy, saved copy and active copy
  // ----------------------------------------------------------------------
  wire save_cmd;
  wire sys_reset_cmd;
  assign save_cmd = wr_ctl && !program_running && wdata_q[`CTL_SAVE];
  assign sys_reset_cmd = wr_ctl && !program_running &&
                         wdata_q[`CTL_SYS_RESET];

  always @(posedge aclk) begin
    if (!aresetn) begin
      reload_pending <= 1'b1;
      driver_ready_gate_enable <= `GATE_FACTORY_DEFAULT;
      pending_gate_enable <= `GATE_FACTORY_DEFAULT;
      nv_write <= 1'b0;
      nv_write_value <= 1'b0;
    end else begin
      reload_pending <= 1'b0;
      nv_write <= save_cmd;
      if (save_cmd) begin
        nv_write_value <= pending_gate_enable;
      end
      if (reload_pending || sys_reset_cmd) begin
        // active value comes from the stored copy, or the factory default when none is saved
        if (nv_saved_valid) begin
          driver_ready_gate_enable <= nv_saved_value;
          pending_gate_enable <= nv_saved_value;
        end else begin
          driver_ready_gate_enable <= `GATE_FACTORY_DEFAULT;
          pending_gate_enable <= `GATE_FACTORY_DEFAULT;
        end
      end else if (wr_ctl && !program_running) begin
        // single bit field: only 0 or 1 can be held
        pending_gate_enable <= wdata_q[`CTL_GATE_ENABLE];
      end
    end
  end

  // ----------------------------------------------------------------------
  // start gating state machine
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      wait_count <= 27'h000_0000;
      pulse_generation_start <= 1'b0;
      start_pending <= 1'b0;
      ev_alarm <= 1'b0;
      ev_started <= 1'b0;
    end else begin
      pulse_generation_start <= 1'b0;
      ev_alarm <= 1'b0;
      ev_started <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (motion_start_request) begin
            // ready is sampled before any pulse
            if (!driver_ready_gate_enable || driver_ready_input_state) begin
              pulse_generation_start <= 1'b1;
              ev_started <= 1'b1;
            end else begin
              state <= ST_WAIT;
              start_pending <= 1'b1;
              wait_count <= 27'h000_0000;
            end
          end
        end
        ST_WAIT: begin
          if (driver_ready_input_state) begin
            pulse_generation_start <= 1'b1;
            ev_started <= 1'b1;
            start_pending <= 1'b0;
            state <= ST_IDLE;
          end else if ({5'h00, wait_count} >= TIMEOUT_LAST) begin
            // driver too slow: alarm and drop request
            ev_alarm <= 1'b1;
            start_pending <= 1'b0;
            state <= ST_IDLE;
          end else begin
            wait_count <= wait_count + 27'h000_0001;
          end
        end
        default: begin
          state <= ST_IDLE;
          start_pending <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // controller ready output
  // ----------------------------------------------------------------------
  wire ctl_idle;
  wire ready_next;
  assign ctl_idle = !controller_moving && !program_running &&
                    !controller_alarm && !driver_connection_alarm &&
                    !start_pending;
  assign ready_next = ctl_idle &&
                      (!driver_ready_gate_enable || driver_ready_input_state);

  always @(posedge aclk) begin
    if (!aresetn) begin
      controller_ready_output_state <= 1'b0;
      remote_ready_output_state <= 1'b0;
    end else begin
      controller_ready_output_state <= ready_next;
      remote_ready_output_state <= ready_next;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status, mask and connection alarm
  // ----------------------------------------------------------------------
  wire [`IRQ_WIDTH-1:0] irq_events;
  wire [`IRQ_WIDTH-1:0] irq_clear;
  wire irq_wr;
  assign irq_events = {ev_refused, ev_started, ev_alarm};
  assign irq_wr = wr_do && wstrb_q[0];
  assign irq_clear = (irq_wr && awaddr_q == `OFS_IRQ_STATUS) ?
                     wdata_q[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};
  assign irq = |(irq_status & irq_mask);

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= {`IRQ_WIDTH{1'b0}};
      irq_mask <= {`IRQ_WIDTH{1'b0}};
      ev_refused <= 1'b0;
      driver_connection_alarm <= 1'b0;
      alarm_code <= 8'h00;
    end else begin
      ev_refused <= wr_refused;
      // a new event wins over a clear in the same cycle
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      if (irq_wr && awaddr_q == `OFS_IRQ_MASK) begin
        irq_mask <= wdata_q[`IRQ_WIDTH-1:0];
      end
      if (ev_alarm) begin
        driver_connection_alarm <= 1'b1;
        alarm_code <= `ALARM_CODE_CONN;
      end else if (irq_clear[`IRQ_CONN_ALARM]) begin
        driver_connection_alarm <= 1'b0;
        alarm_code <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------
  reg [31:0] rd_mux;
  reg rd_ok;
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OFS_CONTROL: begin
        rd_mux[`CTL_GATE_ENABLE] = pending_gate_enable;
      end
      `OFS_STATUS: begin
        rd_mux[`STA_GATE_ACTIVE] = driver_ready_gate_enable;
        rd_mux[`STA_DRV_READY] = driver_ready_input_state;
        rd_mux[`STA_CTRL_READY] = controller_ready_output_state;
        rd_mux[`STA_PENDING] = start_pending;
        rd_mux[`STA_PROGRAM] = program_running;
        rd_mux[`STA_CONN_ALARM] = driver_connection_alarm;
      end
      `OFS_IRQ_STATUS: begin
        rd_mux[`IRQ_WIDTH-1:0] = irq_status;
      end
      `OFS_IRQ_MASK: begin
        rd_mux[`IRQ_WIDTH-1:0] = irq_mask;
      end
      `OFS_ALARM_CODE: begin
        rd_mux[7:0] = alarm_code;
      end
      `OFS_SAVED: begin
        rd_mux[0] = nv_saved_value;
        rd_mux[1] = nv_saved_valid;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** drv_gate_monitor.sv ***
// assertion checker of the start gate ports
`timescale 1ns/1ps
module drv_gate_monitor #(
  parameter [31:0] TIMEOUT_CYCLES = 32'h0000_0032
) (
  input wire aclk,
  input wire aresetn,
  input wire motion_start_request,
  input wire controller_moving,
  input wire program_running,
  input wire controller_alarm,
  input wire nv_write,
  input wire pulse_generation_start,
  input wire start_pending,
  input wire driver_connection_alarm,
  input wire [7:0] alarm_code,
  input wire controller_ready_output_state,
  input wire remote_ready_output_state
);
  reg [31:0] wait_cnt;
  wire busy = controller_moving | program_running | controller_alarm;
  wire req = motion_start_request & !start_pending & !driver_connection_alarm;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------------
  // cycles spent waiting on driver ready
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn || !start_pending) begin
      wait_cnt <= 32'h0000_0000;
    end else begin
      wait_cnt <= wait_cnt + 32'h0000_0001;
    end
  end
  property p_code;
    alarm_code == (driver_connection_alarm ? 8'h6F : 8'h00);
  endproperty
  a_code: assert property (p_code) else $error("alarm code wrong");
  property p_timeout;
    wait_cnt <= TIMEOUT_CYCLES + 32'h0000_0002;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("wait too long");
  property p_remote;
    remote_ready_output_state == controller_ready_output_state;
  endproperty
  a_remote: assert property (p_remote) else $error("remote ready");
  property p_busy;
    $past(busy) |-> !controller_ready_output_state;
  endproperty
  a_busy: assert property (p_busy)
    else $error("ready while busy");
  property p_pend;
    start_pending |=> !controller_ready_output_state;
  endproperty
  a_pend: assert property (p_pend)
    else $error("ready while pending");
  property p_req;
    req |=> pulse_generation_start || start_pending;
  endproperty
  a_req: assert property (p_req) else $error("request lost");
  property p_exit;
    $fell(start_pending) |->
      ##[0:1] (pulse_generation_start || driver_connection_alarm);
  endproperty
  a_exit: assert property (p_exit) else $error("pending dropped");
  property p_abandon;
    $rose(driver_connection_alarm) |-> !pulse_generation_start;
  endproperty
  a_abandon: assert property (p_abandon)
    else $error("pulse on alarm");
  property p_nvw;
    nv_write |=> !nv_write;
  endproperty
  a_nvw: assert property (p_nvw) else $error("save pulse long");
  c_pulse: cover property (pulse_generation_start);
  c_pend: cover property ($rose(start_pending));
  c_alarm: cover property ($rose(driver_connection_alarm));
endmodule

bind driver_ready_start_gating drv_gate_monitor #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) drv_gate_monitor_i (
  .aclk(aclk), .aresetn(aresetn), .motion_start_request(motion_start_request),
  .controller_moving(controller_moving), .program_running(program_running),
  .controller_alarm(controller_alarm), .nv_write(nv_write),
  .pulse_generation_start(pulse_generation_start),
  .start_pending(start_pending),
  .driver_connection_alarm(driver_connection_alarm), .alarm_code(alarm_code),
  .controller_ready_output_state(controller_ready_output_state),
  .remote_ready_output_state(remote_ready_output_state)
);

// *** drv_gate_regs.vh ***
// register map, field positions and timing constants of the start gate
`ifndef DRV_GATE_REGS_VH
`define DRV_GATE_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_ALARM_CODE 8'h10
`define OFS_SAVED 8'h14

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define CTL_GATE_ENABLE 0
`define CTL_SAVE 1
`define CTL_SYS_RESET 2

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define STA_GATE_ACTIVE 0
`define STA_DRV_READY 1
`define STA_CTRL_READY 2
`define STA_PENDING 3
`define STA_PROGRAM 4
`define STA_CONN_ALARM 5

// ----------------------------------------------------------------------
// interrupt fields
// ----------------------------------------------------------------------
`define IRQ_CONN_ALARM 0
`define IRQ_STARTED 1
`define IRQ_REFUSED 2
`define IRQ_WIDTH 3

// ----------------------------------------------------------------------
// values and timing
// ----------------------------------------------------------------------
`define GATE_FACTORY_DEFAULT 1'b0
`define ALARM_CODE_CONN 8'h6F
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define CLK_KHZ 32'h0000_61A8
`define DRV_TIMEOUT_MS 32'h0000_0BB8
`define DRV_TIMEOUT_CYCLES (`DRV_TIMEOUT_MS * `CLK_KHZ)

`endif

// *** motor_driver_model.sv ***
// motor driver model raising operation ready after a delay
`timescale 1ns/1ps
module motor_driver_model (
  input wire aclk,
  input wire want_ready,
  input wire [7:0] ready_delay,
  output reg ready_pin
);
  reg [7:0] cnt = 8'h00;
  initial ready_pin = 1'b0;
  always @(posedge aclk) begin
    if (!want_ready) begin
      cnt <= 8'h00;
      ready_pin <= 1'b0;
    end else if (cnt >= ready_delay) begin
      ready_pin <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// *** pin_sync3.v ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 (
  input wire aclk,
  input wire aresetn,
  input wire pin,
  output reg level
);
  reg s1;
  reg s2;
  reg s3;

  // ----------------------------------------------------------------------
  // s1 feeds only s2; level follows once s2 and s3 agree
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

// *** tb_driver_ready_start_gating.sv ***
// self-checking bench of the driver ready start gate
`timescale 1ns/1ps
`include "drv_gate_regs.vh"
module tb_driver_ready_start_gating;
  localparam [31:0] tmo = 32'h0000_0032;
  reg aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  reg bready = 1'b0, arvalid = 1'b0, rready = 1'b0, req = 1'b0;
  reg mov = 1'b0, prg = 1'b0, alm = 1'b0, nvv = 1'b0, nvd = 1'b0;
  reg want = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00, dly = 8'h00, rnd = 8'h22;
  reg [31:0] wdata = 32'h0000_0000;
  reg [73:0] rd_q [$];
  reg [73:0] e;
  reg [1:0] wr_q [$];
  wire awready, wready, bvalid, arready, rvalid, pin, nvw, nvwd, pulse;
  wire pend, calarm, rdy, rrdy, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] code;
  int error_cnt = 0, checked = 0, cyc = 0, n, i;
  always #20 aclk = ~aclk;
  driver_ready_start_gating #(.TIMEOUT_CYCLES(tmo))
    driver_ready_start_gating_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .driver_ready_pin(pin),
    .motion_start_request(req), .controller_moving(mov),
    .program_running(prg), .controller_alarm(alm), .nv_saved_valid(nvv),
    .nv_saved_value(nvd), .nv_write(nvw), .nv_write_value(nvwd),
    .pulse_generation_start(pulse), .start_pending(pend),
    .driver_connection_alarm(calarm), .alarm_code(code),
    .controller_ready_output_state(rdy), .remote_ready_output_state(rrdy),
    .irq(irq));
  motor_driver_model motor_driver_model_i (.aclk(aclk), .want_ready(want),
    .ready_delay(dly), .ready_pin(pin));
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task report_and_stop;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task check(input string w, input [31:0] x, input [31:0] g);
    checked = checked + 1;
    if (g !== x) begin
      error_cnt = error_cnt + 1;
      $display("Error %s expected %h seen %h", w, x, g);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task rd(input [7:0] a, input [31:0] m, input [31:0] x, input [1:0] r);
    rd_q.push_back({r, a, m, x});
    @(posedge aclk) {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    reg ad, wd;
    wr_q.push_back(r);
    @(posedge aclk) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    {ad, wd} = 2'b00;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
  endtask
  task start;
    @(posedge aclk) req <= 1'b1;
    @(posedge aclk) req <= 1'b0;
    @(negedge aclk);
  endtask
  // nonvolatile store outside the block
  always @(posedge aclk) if (nvw === 1'b1) {nvv, nvd} <= {1'b1, nvwd};
  // write responses and read results against the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready) begin
      check("bresp", wr_q.pop_front(), bresp);
    end
    if (rvalid && rready) begin
      e = rd_q.pop_front();
      check("rdata", e[31:0], rdata & e[63:32]);
      check("rresp", e[73:72], rresp);
    end
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  initial begin
    tick(5);
    aresetn <= 1'b1;
    tick(2);
    rd(`OFS_STATUS, 32'h0000_0001, 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000, `RESP_OKAY);
    rd(8'h18, 32'hFFFF_FFFF, 32'h0000_0000, `RESP_SLVERR);
    @(negedge aclk) check("ready_out", 1'b1, rdy);
    start;
    check("pulse_off", 1'b1, pulse);
    for (i = 0; i < 3; i++) begin
      @(posedge aclk) {alm, prg, mov} <= 3'b001 << i;
      tick(3);
      {alm, prg, mov} <= 3'b000;
      @(negedge aclk) check("ready_busy", 1'b0, rdy);
    end
    $display("test disabled done");
    wr(`OFS_CONTROL, 32'h0000_0001, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h0000_0001, 32'h0000_0000, `RESP_OKAY);
    wr(`OFS_CONTROL, 32'h0000_0003, `RESP_OKAY);
    rd(`OFS_SAVED, 32'h0000_0003, 32'h0000_0003, `RESP_OKAY);
    wr(`OFS_CONTROL, 32'h0000_0005, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h0000_0001, 32'h0000_0001, `RESP_OKAY);
    wr(`OFS_CONTROL, 32'h0000_0000, `RESP_OKAY);
    aresetn <= 1'b0;
    tick(5);
    aresetn <= 1'b1;
    tick(2);
    rd(`OFS_STATUS, 32'h0000_0001, 32'h0000_0001, `RESP_OKAY);
    $display("test save done");
    prg <= 1'b1;
    wr(`OFS_IRQ_MASK, 32'h0000_0004, `RESP_OKAY);
    wr(`OFS_CONTROL, 32'h0000_0000, `RESP_SLVERR);
    rd(`OFS_CONTROL, 32'h0000_0001, 32'h0000_0001, `RESP_OKAY);
    @(negedge aclk) check("irq_set", 1'b1, irq);
    wr(`OFS_IRQ_STATUS, 32'h0000_0004, `RESP_OKAY);
    @(negedge aclk) check("irq_clr", 1'b0, irq);
    @(posedge aclk) {prg, want} <= 2'b01;
    tick(10);
    check("ready_drv", 1'b1, rdy);
    check("remote_drv", 1'b1, rrdy);
    start;
    check("pulse_now", 1'b1, pulse);
    @(posedge aclk) want <= 1'b0;
    tick(10);
    check("ready_nodrv", 1'b0, rdy);
    $display("test enabled done");
    rnd = lfsr(rnd);
    dly <= rnd & 8'h0F;
    start;
    check("pending", 1'b1, pend);
    check("pulse_held", 1'b0, pulse);
    @(posedge aclk) want <= 1'b1;
    for (n = 0; n < 40 && pulse !== 1'b1; n++) @(negedge aclk);
    check("pulse_late", 1'b1, pulse);
    @(posedge aclk) want <= 1'b0;
    tick(10);
    start;
    for (n = 0; n < 60 && calarm !== 1'b1; n++) begin
      @(negedge aclk) check("pulse_none", 1'b0, pulse);
    end
    check("alarm", 1'b1, calarm);
    check("alarm_time", tmo + 32'h0000_0001, n);
    rd(`OFS_ALARM_CODE, 32'h0000_00FF, 32'h0000_006F, `RESP_OKAY);
    wr(`OFS_IRQ_STATUS, 32'h0000_0001, `RESP_OKAY);
    @(negedge aclk) check("alarm_clr", 1'b0, calarm);
    $display("test timeout done");
    report_and_stop;
  end
endmodule
